/* File: rtl/abu_cpu.sv */
// cpu-side controller end: ahb-lite slave that drives the breakpoint link
`timescale 1ns/1ps
`include "abu_regs.svh"
module abu_cpu
  import abu_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic [15:0] pc_addr,
  input wire logic pc_valid,
  input wire logic last_cycle,
  input wire logic at_boundary,
  input wire logic rti_exec,
  input wire logic in_wait,
  input wire logic in_stop,
  input wire logic test_high_voltage,
  input wire logic status_access,
  output logic in_break,
  output logic wake,
  output logic freeze,
  output logic watchdog_off,
  output logic clear_ok,
  abu_if.cpu link
);
  // ==========================================
  // state
  typedef enum logic [1:0] {ABU_IDLE = 2'b00, ABU_REQ = 2'b01, ABU_WAITRD = 2'b11} abu_op_t;
  typedef struct packed {
    abu_op_t op;
    logic dph;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic wr;
    logic rd;
    abu_idx_t idx;
    abu_byte_t wdata;
    abu_byte_t rbyte;
    logic [`ABU_IRQ_BITS-1:0] istat;
    logic [`ABU_IRQ_BITS-1:0] imask;
    logic ack;
    logic brk;
    logic [31:0] hrdata;
    logic irq;
    logic wake;
    logic freeze;
    logic wdog;
    logic clr;
  } abu_cpu_state_t;
  abu_cpu_state_t st;
  abu_cpu_state_t next_st;
  logic done_evt;

  always_comb begin
    next_st = st;
    done_evt = 1'b0;
    next_st.wr = 1'b0;
    next_st.rd = 1'b0;
    next_st.ack = 1'b0;
    next_st.hrdata = 32'h0;
    // register access sequencer: one byte register per command
    unique case (st.op)
      ABU_IDLE: ;
      ABU_REQ: begin
        next_st.op = st.wr ? ABU_IDLE : ABU_WAITRD;
        done_evt = st.wr;
      end
      ABU_WAITRD: begin
        next_st.rbyte = link.reg_rdata;
        next_st.op = ABU_IDLE;
        done_evt = 1'b1;
      end
      default: next_st.op = ABU_IDLE;
    endcase
    // ahb data phase; every access is zero wait
    if (st.dph) begin
      if (st.dph_wr) begin
        unique case (st.dph_addr)
          `ABU_AHB_CMD: begin
            if (st.op == ABU_IDLE) begin
              next_st.op = ABU_REQ;
              next_st.wdata = hwdata[7:0];
              next_st.wr = hwdata[`ABU_CMD_WR_BIT];
              next_st.rd = !hwdata[`ABU_CMD_WR_BIT];
              next_st.idx = hwdata[`ABU_CMD_IDX_LSB +: 3];
            end
          end
          `ABU_AHB_IRQ_STAT: next_st.istat = st.istat & ~hwdata[`ABU_IRQ_BITS-1:0];
          `ABU_AHB_IRQ_MASK: next_st.imask = hwdata[`ABU_IRQ_BITS-1:0];
          default: ;
        endcase
      end
    end
    // events set sticky bits after any clear, so set wins
    if (done_evt) begin
      next_st.istat[`ABU_IRQ_DONE] = 1'b1;
    end
    if (link.break_req && !st.ack && at_boundary && !st.brk) begin
      next_st.ack = 1'b1;
      next_st.brk = 1'b1;
      next_st.istat[`ABU_IRQ_BREAK] = 1'b1;
    end
    if (rti_exec) begin
      next_st.brk = 1'b0;
    end
    // read data for the next data phase
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        `ABU_AHB_CMD: next_st.hrdata = {20'h0, st.idx, 1'b0, st.wdata};
        `ABU_AHB_RDATA: next_st.hrdata = {24'h0, st.rbyte};
        `ABU_AHB_STATUS: next_st.hrdata = {29'h0, st.brk, link.break_req, st.op != ABU_IDLE};
        `ABU_AHB_IRQ_STAT: next_st.hrdata = {30'h0, st.istat};
        `ABU_AHB_IRQ_MASK: next_st.hrdata = {30'h0, st.imask};
        default: next_st.hrdata = 32'h0;
      endcase
    end
    next_st.dph = hsel && hready && htrans[1];
    next_st.dph_wr = hwrite;
    next_st.dph_addr = haddr[7:0];
    next_st.irq = |(next_st.istat & next_st.imask);
    next_st.wake = link.wake_req;
    next_st.freeze = link.timer_freeze;
    next_st.wdog = link.watchdog_disable;
    next_st.clr = link.status_clear_ok;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ==========================================
  // link drive
  assign link.cpu_addr = pc_addr;
  assign link.cpu_addr_valid = pc_valid;
  assign link.cpu_last_cycle = last_cycle;
  assign link.break_ack = st.ack;
  assign link.rti_exec = rti_exec;
  assign link.in_wait = in_wait;
  assign link.in_stop = in_stop;
  assign link.test_high_voltage = test_high_voltage;
  assign link.reg_wr = st.wr;
  assign link.reg_rd = st.rd;
  assign link.reg_idx = st.idx;
  assign link.reg_wdata = st.wdata;
  assign link.status_access = status_access;
  assign hrdata = st.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = st.irq;
  assign in_break = st.brk;
  assign wake = st.wake;
  assign freeze = st.freeze;
  assign watchdog_off = st.wdog;
  assign clear_ok = st.clr;
endmodule : abu_cpu

/* File: pkg/abu_regs.svh */
// register offsets, field positions and reset values of the breakpoint unit
`ifndef ABU_REGS_SVH
`define ABU_REGS_SVH
// ==========================================
// device register indices (8-bit, link side)
`define ABU_IDX_CTRL 3'h0
`define ABU_IDX_ADDRH 3'h1
`define ABU_IDX_ADDRL 3'h2
`define ABU_IDX_WAKE 3'h3
`define ABU_IDX_FCLR 3'h4
// ==========================================
// field positions
`define ABU_BIT_ENABLE 7
`define ABU_BIT_ACTIVE 6
`define ABU_BIT_WAKE 1
`define ABU_BIT_FCE 0
`define ABU_REG_RESET 8'h00
// ==========================================
// controller ahb-lite map (byte addresses)
`define ABU_AHB_CMD 8'h00
`define ABU_AHB_RDATA 8'h04
`define ABU_AHB_STATUS 8'h08
`define ABU_AHB_IRQ_STAT 8'h0c
`define ABU_AHB_IRQ_MASK 8'h10
// command word fields
`define ABU_CMD_WR_BIT 8
`define ABU_CMD_IDX_LSB 9
// irq status bits
`define ABU_IRQ_DONE 0
`define ABU_IRQ_BREAK 1
`define ABU_IRQ_BITS 2
`endif

/* File: pkg/abu_pkg.sv */
// types shared by both ends of the breakpoint unit
package abu_pkg;
  typedef logic [2:0] abu_idx_t;
  typedef logic [7:0] abu_byte_t;
  typedef logic [15:0] abu_addr_t;
endpackage : abu_pkg

/* File: pkg/abu_if.sv */
// link between the breakpoint device and its cpu-side controller
`timescale 1ns/1ps
interface abu_if;
  import abu_pkg::*;
  logic [15:0] cpu_addr;
  logic cpu_addr_valid;
  logic cpu_last_cycle;
  logic break_ack;
  logic rti_exec;
  logic in_wait;
  logic in_stop;
  logic test_high_voltage;
  logic reg_wr;
  logic reg_rd;
  logic [2:0] reg_idx;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic status_access;
  logic break_req;
  logic break_immediate;
  logic wake_req;
  logic timer_freeze;
  logic watchdog_disable;
  logic status_clear_ok;
  modport device (
    input cpu_addr, cpu_addr_valid, cpu_last_cycle, break_ack, rti_exec, in_wait, in_stop,
    test_high_voltage, reg_wr, reg_rd, reg_idx, reg_wdata, status_access,
    output reg_rdata, break_req, break_immediate, wake_req, timer_freeze, watchdog_disable,
    status_clear_ok
  );
  modport cpu (
    output cpu_addr, cpu_addr_valid, cpu_last_cycle, break_ack, rti_exec, in_wait, in_stop,
    test_high_voltage, reg_wr, reg_rd, reg_idx, reg_wdata, status_access,
    input reg_rdata, break_req, break_immediate, wake_req, timer_freeze, watchdog_disable,
    status_clear_ok
  );
endinterface : abu_if

/* File: rtl/abu_sync.sv */
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
module abu_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  logic [2:0] stage;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage <= 3'h0;
      dout <= 1'b0;
    end else if (ce) begin
      stage <= {stage[1:0], din};
      // only stages two and three are compared, never stage one
      if (stage[1] == stage[2]) begin
        dout <= stage[2];
      end
    end
  end
endmodule : abu_sync

/* File: rtl/abu_device.sv */
// breakpoint unit device end: address compare, break state, flags
`timescale 1ns/1ps
`include "abu_regs.svh"
module abu_device
  import abu_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  abu_if.device link
);
  // ==========================================
  // state
  typedef struct packed {
    // software-visible control and status
    logic enable;
    logic active;
    // breakpoint address, two byte registers
    abu_byte_t addr_high;
    abu_byte_t addr_low;
    // wait/stop exit flag and clear gate
    logic wake_flag;
    logic fce;
    // break request handshake toward the cpu
    logic pending;
    logic in_break;
    logic immediate;
    // wake request out of wait or stop
    logic wake;
    // read data, valid the cycle after a read pulse
    abu_byte_t rdata;
  } abu_dev_state_t;
  abu_dev_state_t st;
  abu_dev_state_t next_st;
  logic tv_sync;
  logic match;

  abu_sync u_tv_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .din(link.test_high_voltage),
    .dout(tv_sync)
  );

  function automatic abu_byte_t read_reg(input abu_dev_state_t s, input abu_idx_t idx);
    abu_byte_t v;
    v = 8'h00;
    unique case (idx)
      `ABU_IDX_CTRL: begin
        v[`ABU_BIT_ENABLE] = s.enable;
        v[`ABU_BIT_ACTIVE] = s.active;
      end
      `ABU_IDX_ADDRH: v = s.addr_high;
      `ABU_IDX_ADDRL: v = s.addr_low;
      `ABU_IDX_WAKE: v[`ABU_BIT_WAKE] = s.wake_flag;
      `ABU_IDX_FCLR: v[`ABU_BIT_FCE] = s.fce;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  // ==========================================
  // helpers
  function automatic abu_addr_t bp_word(input abu_dev_state_t s);
    return {s.addr_high, s.addr_low};
  endfunction : bp_word

  // a write of zero to active clears it; a one forces a break
  function automatic abu_dev_state_t write_reg(input abu_dev_state_t s, input abu_idx_t idx,
      input abu_byte_t d);
    abu_dev_state_t n;
    n = s;
    unique case (idx)
      `ABU_IDX_CTRL: begin
        n.enable = d[`ABU_BIT_ENABLE];
        if (d[`ABU_BIT_ACTIVE]) begin
          n.active = 1'b1;
          n.pending = 1'b1;
        end else begin
          n.active = 1'b0;
        end
      end
      `ABU_IDX_ADDRH: n.addr_high = d;
      `ABU_IDX_ADDRL: n.addr_low = d;
      `ABU_IDX_WAKE: begin
        // a one has no effect, so a read-modify-write cannot set it
        if (!d[`ABU_BIT_WAKE]) begin
          n.wake_flag = 1'b0;
        end
      end
      `ABU_IDX_FCLR: n.fce = d[`ABU_BIT_FCE];
      default: ;
    endcase
    return n;
  endfunction : write_reg

  // ==========================================
  // next state
  always_comb begin
    next_st = st;
    // compare against the cpu program address only when it is valid
    match = st.enable && link.cpu_addr_valid && (link.cpu_addr == bp_word(st));
    if (link.reg_rd) begin
      next_st.rdata = read_reg(st, link.reg_idx);
    end
    if (link.reg_wr) begin
      next_st = write_reg(next_st, link.reg_idx, link.reg_wdata);
    end
    // match set wins over a software clear in the same cycle
    if (match) begin
      next_st.active = 1'b1;
      next_st.pending = 1'b1;
      next_st.immediate = link.cpu_last_cycle;
    end else if (!st.pending) begin
      next_st.immediate = 1'b0;
    end
    // wake from stop or wait on any pending break, forced or matched
    next_st.wake = next_st.pending && (link.in_stop || link.in_wait);
    if (next_st.wake) begin
      next_st.wake_flag = 1'b1;
    end
    // request stands until the cpu takes it at a boundary
    if (link.break_ack) begin
      next_st.pending = 1'b0;
      next_st.immediate = 1'b0;
      next_st.in_break = 1'b1;
    end
    if (link.rti_exec && st.in_break) begin
      next_st.in_break = 1'b0;
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign link.reg_rdata = st.rdata;
  assign link.break_req = st.pending;
  assign link.break_immediate = st.immediate;
  assign link.wake_req = st.wake;
  assign link.timer_freeze = st.in_break;
  // synchronised pin level; limitation: four-cycle lag on the test voltage
  assign link.watchdog_disable = st.in_break && tv_sync;
  assign link.status_clear_ok = !st.in_break || st.fce;
endmodule : abu_device

/* File: bench/abu_properties.sv */
// concurrent checks on the link between the two breakpoint ends
`timescale 1ns/1ps
module abu_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_addr_valid,
  input wire logic cpu_last_cycle,
  input wire logic break_ack,
  input wire logic rti_exec,
  input wire logic in_stop,
  input wire logic reg_wr,
  input wire logic [2:0] reg_idx,
  input wire logic [7:0] reg_wdata,
  input wire logic break_req,
  input wire logic break_immediate,
  input wire logic wake_req,
  input wire logic timer_freeze,
  input wire logic watchdog_disable,
  input wire logic status_clear_ok
);
  // ====
  // shadow of enable and address, taken from link writes
  logic en;
  logic [15:0] bp;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en <= 1'h0;
      bp <= 16'h0000;
    end else if (reg_wr && reg_idx == 3'h0) begin
      en <= reg_wdata[7];
    end else if (reg_wr && reg_idx == 3'h1) begin
      bp[15:8] <= reg_wdata;
    end else if (reg_wr && reg_idx == 3'h2) begin
      bp[7:0] <= reg_wdata;
    end
  end
  // ====
  // properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // same-cycle writes excluded: shadow and device may disagree there
  sequence s_match;
    en && cpu_addr_valid && cpu_addr == bp && !reg_wr && !break_ack;
  endsequence
  sequence s_force;
    reg_wr && reg_idx == 3'h0 && reg_wdata[6] && !break_ack;
  endsequence
  a_match_break: assert property (s_match |=> break_req)
    else $error("match gave no break request");
  a_last_immed: assert property (s_match ##0 cpu_last_cycle |=> break_immediate)
    else $error("last-cycle match not immediate");
  a_soft_force: assert property (s_force |=> break_req)
    else $error("forced break not requested");
  a_req_held: assert property (break_req && !break_ack |=> break_req)
    else $error("break request dropped before ack");
  a_freeze_start: assert property (break_ack |-> ##[1:2] timer_freeze)
    else $error("no freeze after ack");
  a_freeze_hold: assert property (timer_freeze && !rti_exec |=> timer_freeze)
    else $error("freeze dropped without return");
  a_rti_unfreeze: assert property (rti_exec |-> ##[1:2] !timer_freeze)
    else $error("return left freeze on");
  a_wdog_break: assert property (watchdog_disable |-> timer_freeze)
    else $error("watchdog off outside break");
  a_clear_gate: assert property ($fell(status_clear_ok) |-> timer_freeze || $past(timer_freeze))
    else $error("clear blocked outside break");
  a_stop_wake: assert property ((break_req && in_stop) [*3] |-> wake_req)
    else $error("pending break gave no wake");
endmodule : abu_properties

/* File: bench/tb.sv */
// self-checking bench: both ends joined by the link, driven over ahb-lite
`timescale 1ns/1ps
`include "abu_regs.svh"
module tb;
  logic hclk, hresetn, hsel, hwrite, hready, pc_valid, last_cycle, at_boundary;
  logic rti_exec, in_wait, in_stop, test_high_voltage, status_access;
  logic hreadyout, hresp, irq, in_break, wake, freeze, watchdog_off, clear_ok;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] pc_addr;
  int error_cnt, total_checks;
  abu_if link();
  assign hready = hreadyout;
  abu_device u_abu_device (.hclk, .hresetn, .ce(1'h1), .link(link));
  abu_cpu u_abu_cpu (.hclk, .hresetn, .ce(1'h1), .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq, .pc_addr, .pc_valid, .last_cycle,
    .at_boundary, .rti_exec, .in_wait, .in_stop, .test_high_voltage, .status_access,
    .in_break, .wake, .freeze, .watchdog_off, .clear_ok, .link(link));
  abu_properties u_abu_properties (.hclk, .hresetn, .cpu_addr(link.cpu_addr),
    .cpu_addr_valid(link.cpu_addr_valid), .cpu_last_cycle(link.cpu_last_cycle),
    .break_ack(link.break_ack), .rti_exec(link.rti_exec), .in_stop(link.in_stop),
    .reg_wr(link.reg_wr), .reg_idx(link.reg_idx), .reg_wdata(link.reg_wdata),
    .break_req(link.break_req), .break_immediate(link.break_immediate),
    .wake_req(link.wake_req), .timer_freeze(link.timer_freeze),
    .watchdog_disable(link.watchdog_disable), .status_clear_ok(link.status_clear_ok));
  // ====
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  // command then poll the sticky done bit; leaves the read byte in rd
  task automatic dev(input logic [2:0] i, input logic w, input logic [7:0] d);
    bus(`ABU_AHB_IRQ_STAT, 1'h1, 32'h1);
    bus(`ABU_AHB_CMD, 1'h1, {20'h0, i, w, d});
    rd = 32'h0;
    for (int n = 0; n < 20 && rd[0] !== 1'h1; n++) bus(`ABU_AHB_IRQ_STAT, 1'h0, 32'h0);
    bus(`ABU_AHB_RDATA, 1'h0, 32'h0);
  endtask : dev
  task automatic hit;
    pc_addr <= 16'h1234;
    pc_valid <= 1'h1;
    @(posedge hclk);
    pc_valid <= 1'h0;
    repeat (3) @(posedge hclk);
  endtask : hit
  task automatic wait_break(input logic v);
    for (int k = 0; k < 12 && in_break !== v; k++) @(posedge hclk);
    repeat (2) @(posedge hclk);
  endtask : wait_break
  task automatic interrupt_return_opcode;
    rti_exec <= 1'h1;
    @(posedge hclk);
    rti_exec <= 1'h0;
    wait_break(1'h0);
  endtask : interrupt_return_opcode
  // ====
  // clock, watchdog, tests
  initial begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    repeat (5000) @(posedge hclk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    hresetn = 1'h0;
    hsel = 1'h1;
    {hwrite, pc_valid, last_cycle, at_boundary, rti_exec, in_wait, in_stop} = '0;
    {test_high_voltage, status_access, haddr, hwdata} = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    pc_addr = 16'h0000;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    for (int i = 0; i < 5; i++) begin
      dev(3'(i), 1'h0, 8'h00);
      chk(rd, 32'h0);
    end
    bus(8'h20, 1'h0, 32'h0);
    chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
    chk(32'(hreadyout), 32'h1);
    dev(3'h1, 1'h1, 8'h12);
    dev(3'h2, 1'h1, 8'h34);
    bus(`ABU_AHB_IRQ_MASK, 1'h1, 32'h2);
    hit();
    bus(`ABU_AHB_STATUS, 1'h0, 32'h0);
    chk(rd, 32'h0);
    dev(3'h1, 1'h0, 8'h00);
    chk(rd, 32'h12);
    dev(3'h0, 1'h1, 8'h80);
    test_high_voltage <= 1'h1;
    last_cycle <= 1'h1;
    at_boundary <= 1'h1;
    hit();
    wait_break(1'h1);
    chk(32'(freeze), 32'h1);
    chk(32'(watchdog_off), 32'h1);
    chk(32'(clear_ok), 32'h0);
    chk(32'(irq), 32'h1);
    dev(3'h0, 1'h0, 8'h00);
    chk(rd, 32'hc0);
    bus(`ABU_AHB_IRQ_STAT, 1'h1, 32'h2);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 32'h0);
    dev(3'h0, 1'h1, 8'h80);
    interrupt_return_opcode();
    chk(32'(freeze), 32'h0);
    test_high_voltage <= 1'h0;
    at_boundary <= 1'h0;
    in_stop <= 1'h1;
    dev(3'h4, 1'h1, 8'h01);
    dev(3'h0, 1'h1, 8'hc0);
    repeat (4) @(posedge hclk);
    chk(32'(wake), 32'h1);
    bus(`ABU_AHB_STATUS, 1'h0, 32'h0);
    chk(rd, 32'h2);
    in_stop <= 1'h0;
    at_boundary <= 1'h1;
    wait_break(1'h1);
    chk(32'(watchdog_off), 32'h0);
    chk(32'(clear_ok), 32'h1);
    dev(3'h3, 1'h0, 8'h00);
    chk(rd, 32'h2);
    dev(3'h3, 1'h1, 8'h00);
    dev(3'h3, 1'h0, 8'h00);
    chk(rd, 32'h0);
    dev(3'h0, 1'h1, 8'h80);
    interrupt_return_opcode();
    print_verdict();
  end
endmodule : tb
